// >>> inc/sample_ctl_defines.vh
// register offsets, field positions, reset values and timing counts for the sample controller
`ifndef SAMPLE_CTL_DEFINES_VH
`define SAMPLE_CTL_DEFINES_VH
// register byte offsets
`define OFS_CONTROL 12'h000
`define OFS_CONTROL_ACT 12'h004
`define OFS_SLOW_CFG 12'h008
`define OFS_BUS_SETTINGS 12'h00C
`define OFS_COMMAND 12'h010
`define OFS_STATUS 12'h014
`define OFS_DATA_COUNT 12'h018
`define OFS_ENERGY 12'h01C
// control fields: [3:0] sample mode, [5:4] pin0 function, [7:6] pin1 function, [8] adaptive acc
`define CTL_MODE_LSB 0
`define CTL_P0F_LSB 4
`define CTL_P1F_LSB 6
`define CTL_ADAPT_BIT 8
`define CONTROL_RST 9'h0F4
// sample modes
`define MODE_1024 4'h4
`define MODE_8SPS 4'h5
`define MODE_BUS_VOLTAGE_RESULT_ONLY 4'hA
`define MODE_SHUNT_ONLY 4'hB
`define MODE_SHOT_A 4'hC
`define MODE_SHOT_B 4'hD
`define MODE_SLEEP_A 4'hE
`define MODE_SLEEP_B 4'hF
// pin functions
`define FN_ALERT 2'h0
`define FN_GPI 2'h1
`define FN_GPO 2'h2
`define FN_SLOW 2'h3
// slow config: [0] keep-totals type, [1] rise enable, [2] fall enable, [3] level, [4] rose, [5] fell
`define SLOW_RST 6'h06
// command codes
`define CMD_FULL 2'h1
`define CMD_KEEP 2'h2
// timing
`define T_BANDGAP_MS 5
`define CLK_MHZ 100
`define BANDGAP_CYC (`T_BANDGAP_MS * 1000 * `CLK_MHZ)
`define CC_1024_CYC 97656
`define CC_8SPS_CYC 12500000
`define CC_FAST_CYC 6103
`endif

// >>> rtl/sync2.v
// two-flop synchroniser for one level
`timescale 1ns/1ps
`default_nettype none
module sync2 (
	input wire hclk,
	input wire hresetn,
	input wire d,
	output wire q
);
	reg s1_r; // first stage, read only by second
	reg s2_r; // second stage
	// -------------------------------
	// two flip-flop chain
	// -------------------------------
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
		end else begin
			s1_r <= d;
			s2_r <= s1_r;
		end
	end
	assign q = s2_r;
endmodule
`default_nettype wire

// >>> rtl/sample_mode_pin_control.v
// sampling state control with sleep, power-down, slow pin and multifunction pins
// Notes on behaviour
// - sleep modes entered after snapshot apply, at conversion end or at once from single-shot idle
// - sleep keeps all registers
// - sleep left by new mode plus snapshot
// - no other sleep cause; timeout unaffected
// - power-down pin low clears everything
// - power-down release acts as power-on reset
// - power-on flag set on every power-on
// - slow input high forces 8 sps next cycle
// - function 11b makes pin slow input
// - pin0 slow input has priority
// - function 00b is alert, no sampling effect
// - mode 0101b selects 8 sps
// - single-shot slow rise waits band-gap start
// - slow rise in sleep only sets level and rose status
// - self snapshot on slow edges, data only
// - slow settings: type, edge enables, status
// - adaptive enable clears slow edge enables
// - mode 1010b samples bus voltage only
// - mode 1011b samples shunt voltage only
// - single-input modes keep accumulation running
// - 01b is gp input, 10b gp output
// - io value bit reads input, drives output
// - full snapshot clears totals, keep-totals not
//
// The register offsets and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "sample_ctl_defines.vh"
module sample_mode_pin_control #(
	parameter BANDGAP_CYC = `BANDGAP_CYC,
	parameter CC_SLOW_CYC = `CC_8SPS_CYC,
	parameter CC_1024_CYC = `CC_1024_CYC
) (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [11:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output wire [31:0] hrdata,
	output wire hreadyout,
	output wire hresp,
	input wire power_down_pin,
	input wire multi_pin_zero_in,
	output wire multi_pin_zero_out,
	output wire multi_pin_zero_oe,
	input wire multi_pin_one_in,
	output wire multi_pin_one_out,
	output wire multi_pin_one_oe,
	input wire alert_zero_req,
	input wire alert_one_req,
	output reg sleeping,
	output reg slow_active,
	output reg sample_bus,
	output reg sample_shunt,
	output reg conv_strobe,
	output reg snap_strobe,
	output reg snap_clear_totals
);
	// ---------------------------------------
	// pin synchronisers
	// ---------------------------------------
	wire pd_s; // power-down pin, synced
	wire p0_s; // pin zero level
	wire p1_s; // pin one level
	sync2 u_pd (.hclk(hclk), .hresetn(hresetn), .d(power_down_pin), .q(pd_s));
	sync2 u_p0 (.hclk(hclk), .hresetn(hresetn), .d(multi_pin_zero_in), .q(p0_s));
	sync2 u_p1 (.hclk(hclk), .hresetn(hresetn), .d(multi_pin_one_in), .q(p1_s));
	wire rst_n = hresetn & pd_s;
	// ---------------------------------------
	// registers
	// ---------------------------------------
	reg [8:0] control_r; // pending control
	reg [8:0] control_act_r; // active control
	reg [5:0] slow_r; // slow pin settings and status
	reg [1:0] io_out_r; // gp output values
	reg por_flag_r; // power-on flag
	reg [31:0] count_r; // sample count total
	reg [31:0] energy_r; // energy total
	reg [31:0] data_count_r; // snapshot of count
	reg [31:0] data_energy_r; // snapshot of energy
	reg adapt_d_r; // previous adaptive bit
	wire [3:0] mode_act = control_act_r[`CTL_MODE_LSB +: 4];
	wire [1:0] p0f = control_act_r[`CTL_P0F_LSB +: 2];
	wire [1:0] p1f = control_act_r[`CTL_P1F_LSB +: 2];
	// ---------------------------------------
	// ahb-lite address phase capture
	// ---------------------------------------
	reg wr_r; // data-phase write pending
	reg rd_r; // data-phase read pending
	reg [11:0] addr_r; // captured address
	wire take = hsel & hready & htrans[1];
	always @(posedge hclk or negedge rst_n) begin
		if (!rst_n) begin
			wr_r <= 1'b0;
			rd_r <= 1'b0;
			addr_r <= 12'h000;
		end else begin
			wr_r <= take & hwrite;
			rd_r <= take & ~hwrite;
			if (take) begin
				addr_r <= haddr;
			end
		end
	end
	assign hreadyout = 1'b1; // zero wait states
	assign hresp = 1'b0; // always okay
	wire cmd_wr = wr_r & (addr_r == `OFS_COMMAND);
	wire cmd_full = cmd_wr & (hwdata[1:0] == `CMD_FULL);
	wire cmd_keep = cmd_wr & (hwdata[1:0] == `CMD_KEEP);
	wire host_snap = cmd_full | cmd_keep;
	// ---------------------------------------
	// pin function decode
	// ---------------------------------------
	wire p0_slow = (p0f == `FN_SLOW) & p0_s;
	wire p1_slow = (p1f == `FN_SLOW) & p1_s;
	wire slow_lvl = p0_slow | (~(p0f == `FN_SLOW) & p1_slow);
	reg slow_d_r; // previous slow level
	wire slow_rise = slow_lvl & ~slow_d_r;
	wire slow_fall = ~slow_lvl & slow_d_r;
	wire is_sleep = (mode_act == `MODE_SLEEP_A) | (mode_act == `MODE_SLEEP_B);
	wire is_shot = (mode_act == `MODE_SHOT_A) | (mode_act == `MODE_SHOT_B);
	// ---------------------------------------
	// control, slow, io and flag registers
	// ---------------------------------------
	always @(posedge hclk or negedge rst_n) begin
		if (!rst_n) begin
			control_r <= `CONTROL_RST;
			control_act_r <= `CONTROL_RST;
			slow_r <= `SLOW_RST;
			io_out_r <= 2'h0;
			por_flag_r <= 1'b1;
			adapt_d_r <= 1'b0;
			slow_d_r <= 1'b0;
		end else begin
			slow_d_r <= slow_lvl;
			adapt_d_r <= control_act_r[`CTL_ADAPT_BIT];
			if (wr_r & (addr_r == `OFS_CONTROL)) begin
				control_r <= hwdata[8:0];
			end
			// snapshot applies pending control, sleep included
			if (host_snap) begin
				control_act_r <= control_r;
			end
			if (wr_r & (addr_r == `OFS_SLOW_CFG)) begin
				slow_r[2:0] <= hwdata[2:0];
			end else if (control_act_r[`CTL_ADAPT_BIT] & ~adapt_d_r) begin
				slow_r[2:1] <= 2'h0;
			end
			slow_r[3] <= slow_lvl;
			// edge records: set wins over clear
			if (slow_rise) begin
				slow_r[4] <= 1'b1;
			end else if (wr_r & (addr_r == `OFS_SLOW_CFG) & hwdata[4]) begin
				slow_r[4] <= 1'b0;
			end
			if (slow_fall) begin
				slow_r[5] <= 1'b1;
			end else if (wr_r & (addr_r == `OFS_SLOW_CFG) & hwdata[5]) begin
				slow_r[5] <= 1'b0;
			end
			if (wr_r & (addr_r == `OFS_BUS_SETTINGS)) begin
				io_out_r <= hwdata[1:0];
				if (hwdata[7]) begin
					por_flag_r <= 1'b0;
				end
			end
		end
	end
	// ---------------------------------------
	// pin drive
	// ---------------------------------------
	assign multi_pin_zero_oe = (p0f == `FN_GPO) | ((p0f == `FN_ALERT) & alert_zero_req);
	assign multi_pin_zero_out = (p0f == `FN_GPO) ? io_out_r[0] : 1'b0;
	assign multi_pin_one_oe = (p1f == `FN_GPO) | ((p1f == `FN_ALERT) & alert_one_req);
	assign multi_pin_one_out = (p1f == `FN_GPO) ? io_out_r[1] : 1'b0;
	// ---------------------------------------
	// conversion sequencer
	// ---------------------------------------
	localparam ST_SLEEP = 4'b0001;
	localparam ST_RUN = 4'b0010;
	localparam ST_BG = 4'b0100;
	localparam ST_IDLE = 4'b1000;
	reg [3:0] state_r; // sequencer state
	reg [31:0] cnt_r; // cycle counter
	reg slow_cyc_r; // current cycle runs at 8 sps
	reg self_snap_r; // pending self snapshot
	reg self_keep_r; // pending type keep-totals
	wire [31:0] cc_len = (slow_lvl | (mode_act == `MODE_8SPS)) ? CC_SLOW_CYC[31:0] :
		((mode_act == `MODE_BUS_VOLTAGE_RESULT_ONLY) | (mode_act == `MODE_SHUNT_ONLY)) ?
		`CC_FAST_CYC : CC_1024_CYC[31:0];
	wire self_trig = (slow_rise & slow_r[1]) | (slow_fall & slow_r[2]);
	always @(posedge hclk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= ST_RUN;
			cnt_r <= 32'h0;
			slow_cyc_r <= 1'b0;
			conv_strobe <= 1'b0;
			self_snap_r <= 1'b0;
			self_keep_r <= 1'b0;
		end else begin
			conv_strobe <= 1'b0;
			if (self_trig & ~is_sleep) begin
				self_snap_r <= 1'b1;
				self_keep_r <= slow_r[0];
			end
			case (state_r)
				ST_SLEEP: begin
					// only an applied non-sleep mode wakes; slow rise ignored
					if (~is_sleep) begin
						state_r <= ST_RUN;
						cnt_r <= 32'h0;
					end
				end
				ST_RUN: begin
					if (cnt_r + 32'h1 >= (slow_cyc_r ? CC_SLOW_CYC[31:0] : cc_len)) begin
						conv_strobe <= 1'b1;
						cnt_r <= 32'h0;
						slow_cyc_r <= slow_lvl | (mode_act == `MODE_8SPS);
						if (is_sleep) begin
							state_r <= ST_SLEEP;
						end else if (is_shot) begin
							state_r <= ST_IDLE;
						end
					end else begin
						cnt_r <= cnt_r + 32'h1;
					end
				end
				ST_BG: begin
					if (cnt_r + 32'h1 >= BANDGAP_CYC[31:0]) begin
						cnt_r <= 32'h0;
						state_r <= ST_RUN;
					end else begin
						cnt_r <= cnt_r + 32'h1;
					end
				end
				ST_IDLE: begin
					if (is_sleep) begin
						state_r <= ST_SLEEP;
					end else if (slow_rise) begin
						state_r <= ST_BG;
						cnt_r <= 32'h0;
					end else if (host_snap | ~is_shot) begin
						state_r <= ST_RUN;
						cnt_r <= 32'h0;
					end
				end
				default: begin
					state_r <= ST_RUN;
				end
			endcase
			if (conv_strobe) begin
				self_snap_r <= 1'b0; // data lands within one cycle
			end
		end
	end
	// ---------------------------------------
	// sampling outputs, totals and snapshots
	// ---------------------------------------
	always @(posedge hclk or negedge rst_n) begin
		if (!rst_n) begin
			sleeping <= 1'b0;
			slow_active <= 1'b0;
			sample_bus <= 1'b1;
			sample_shunt <= 1'b1;
			snap_strobe <= 1'b0;
			snap_clear_totals <= 1'b0;
			count_r <= 32'h0;
			energy_r <= 32'h0;
			data_count_r <= 32'h0;
			data_energy_r <= 32'h0;
		end else begin
			sleeping <= (state_r == ST_SLEEP);
			slow_active <= slow_cyc_r;
			sample_bus <= (mode_act != `MODE_SHUNT_ONLY);
			sample_shunt <= (mode_act != `MODE_BUS_VOLTAGE_RESULT_ONLY);
			snap_strobe <= host_snap | (conv_strobe & self_snap_r);
			snap_clear_totals <= cmd_full | (conv_strobe & self_snap_r & ~self_keep_r);
			// accumulation runs in every sampling mode
			if (host_snap) begin
				data_count_r <= count_r;
				data_energy_r <= energy_r;
			end else if (conv_strobe & self_snap_r) begin
				data_count_r <= count_r;
				data_energy_r <= energy_r;
			end
			if (cmd_full | (conv_strobe & self_snap_r & ~self_keep_r)) begin
				count_r <= 32'h0;
				energy_r <= 32'h0;
			end else if (conv_strobe) begin
				count_r <= count_r + 32'h1;
				energy_r <= energy_r + 32'h1;
			end
		end
	end
	// ---------------------------------------
	// read mux
	// ---------------------------------------
	reg [31:0] rdata_r; // read data
	always @(posedge hclk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_r <= 32'h0;
		end else if (take & ~hwrite) begin
			case (haddr)
				`OFS_CONTROL: rdata_r <= {23'h0, control_r};
				`OFS_CONTROL_ACT: rdata_r <= {23'h0, control_act_r};
				`OFS_SLOW_CFG: rdata_r <= {26'h0, slow_r};
				`OFS_BUS_SETTINGS: rdata_r <= {24'h0, por_flag_r, 5'h0,
					(p1f == `FN_GPI) ? p1_s : io_out_r[1],
					(p0f == `FN_GPI) ? p0_s : io_out_r[0]};
				`OFS_STATUS: rdata_r <= {28'h0, state_r};
				`OFS_DATA_COUNT: rdata_r <= data_count_r;
				`OFS_ENERGY: rdata_r <= data_energy_r;
				default: rdata_r <= 32'h0;
			endcase
		end
	end
	assign hrdata = rd_r ? rdata_r : 32'h0;
endmodule
`default_nettype wire

// >>> dv/pin_far_end.sv
// far-end model of one multifunction pin: pull-up plus outside driver
`timescale 1ns/1ps
`default_nettype none
module pin_far_end (
	input wire logic oe,
	input wire logic out,
	input wire logic ext_en,
	input wire logic ext_val,
	output logic level
);
	// device drive wins, then outside drive, else the pull-up
	assign level = oe ? out : (ext_en ? ext_val : 1'h1);
endmodule
`default_nettype wire

// >>> dv/smpc_props.sv
// port-level assertions for the sample controller
`timescale 1ns/1ps
`default_nettype none
`include "sample_ctl_defines.vh"
module smpc_props (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [11:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire hready,
	input wire power_down_pin,
	input wire sleeping,
	input wire slow_active,
	input wire sample_bus,
	input wire sample_shunt,
	input wire conv_strobe,
	input wire snap_strobe,
	input wire snap_clear_totals
);
	// ----------
	// command age
	// ----------
	logic [7:0] age_r; // cycles since last command write
	logic [7:0] age_nxt;
	wire cmd_ap = hsel & hready & htrans[1] & hwrite & (haddr == `OFS_COMMAND);
	wire recent = age_r < 8'h40; // a command lies in the recent past
	assign age_nxt = cmd_ap ? 8'h00 : ((age_r == 8'hFF) ? age_r : age_r + 8'h01);
	// saturating age counter
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			age_r <= 8'hFF;
		else
			age_r <= age_nxt;
	end
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence s_pd_held;
		!power_down_pin [*4];
	endsequence
	sequence s_asleep;
		sleeping ##1 sleeping;
	endsequence
	a_pd_reset: assert property (s_pd_held |-> !sleeping && sample_bus && sample_shunt)
		else $error("power-down did not reset");
	a_asleep_quiet: assert property (s_asleep |-> !conv_strobe)
		else $error("conversion while asleep");
	a_sleep_cause: assert property ($rose(sleeping) |-> recent)
		else $error("sleep without command");
	a_wake_cause: assert property ($fell(sleeping) && power_down_pin |-> recent)
		else $error("wake without command");
	a_snap_cause: assert property (snap_strobe |-> conv_strobe || $past(conv_strobe) || recent)
		else $error("snapshot without cause");
	a_clear_full: assert property (snap_clear_totals |-> snap_strobe)
		else $error("totals cleared off snapshot");
	a_one_sampled: assert property (!sleeping |-> sample_bus || sample_shunt)
		else $error("no input sampled");
	a_slow_edge: assert property ($rose(slow_active) |-> conv_strobe || $past(conv_strobe) || recent)
		else $error("slow rate off cycle end");
endmodule
bind sample_mode_pin_control smpc_props i_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
	.power_down_pin(power_down_pin), .sleeping(sleeping), .slow_active(slow_active),
	.sample_bus(sample_bus), .sample_shunt(sample_shunt), .conv_strobe(conv_strobe),
	.snap_strobe(snap_strobe), .snap_clear_totals(snap_clear_totals));
`default_nettype wire

// >>> dv/sample_mode_pin_control_bench.sv
// self-checking bench for the sample controller
`timescale 1ns/1ps
`default_nettype none
`include "sample_ctl_defines.vh"
module sample_mode_pin_control_bench;
	// ----------
	// signals
	// ----------
	localparam int SETTLE = 180; // four slow cycles plus margin
	localparam int POR_WAIT = 80; // scaled start-up hold before first snapshot
	logic hclk, hresetn, hsel, hwrite, power_down_pin, alert_zero_req;
	logic [11:0] haddr;
	logic [1:0] htrans;
	logic [31:0] hwdata, v;
	wire hready, hresp, sleeping, slow_active, sample_bus, sample_shunt;
	wire conv_strobe, snap_strobe, snap_clear_totals;
	wire [31:0] hrdata;
	wire oe0, out0, lvl0, oe1, out1, lvl1;
	logic e0_en, e0_v, e1_en, e1_v; // outside pin drivers
	int fail_count, check_count, snap_n;
	logic last_clr; // clear flag of the last snapshot
	sample_mode_pin_control #(.BANDGAP_CYC(20), .CC_SLOW_CYC(40), .CC_1024_CYC(10)) i_dut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hready), .hresp(hresp), .power_down_pin(power_down_pin),
		.multi_pin_zero_in(lvl0), .multi_pin_zero_out(out0), .multi_pin_zero_oe(oe0),
		.multi_pin_one_in(lvl1), .multi_pin_one_out(out1), .multi_pin_one_oe(oe1),
		.alert_zero_req(alert_zero_req), .alert_one_req(alert_zero_req), .sleeping(sleeping),
		.slow_active(slow_active), .sample_bus(sample_bus), .sample_shunt(sample_shunt),
		.conv_strobe(conv_strobe), .snap_strobe(snap_strobe),
		.snap_clear_totals(snap_clear_totals));
	pin_far_end i_pin0 (.oe(oe0), .out(out0), .ext_en(e0_en), .ext_val(e0_v), .level(lvl0));
	pin_far_end i_pin1 (.oe(oe1), .out(out1), .ext_en(e1_en), .ext_val(e1_v), .level(lvl1));
	// snapshot monitor
	always @(posedge hclk) begin
		if (snap_strobe === 1'h1) begin
			snap_n++;
			last_clr = snap_clear_totals;
		end
	end
	// ----------
	// tasks
	// ----------
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// one single AHB transfer, address phase then data phase
	task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'h1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge hclk); while (hready !== 1'h1);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'h1);
		v = hrdata;
	endtask
	task rdchk(input string nm, input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
		xfer(1'h0, a, 32'h0);
		chk(nm, v & m, e);
	endtask
	// pending control then a snapshot command, then let it settle
	task apply(input logic [31:0] c, input logic [1:0] code);
		xfer(1'h1, `OFS_CONTROL, c);
		xfer(1'h1, `OFS_COMMAND, 32'(code));
		repeat (SETTLE) @(posedge hclk);
	endtask
	task t_reset;
		rdchk("control", `OFS_CONTROL, 32'hFFFFFFFF, 32'h000000F4);
		rdchk("slow cfg", `OFS_SLOW_CFG, 32'h3F, 32'h06);
		rdchk("por", `OFS_BUS_SETTINGS, 32'h80, 32'h80);
		xfer(1'h1, `OFS_BUS_SETTINGS, 32'h80);
		rdchk("por cleared", `OFS_BUS_SETTINGS, 32'h80, 32'h0);
	endtask
	task t_sleep;
		apply(32'h0FE, `CMD_FULL);
		chk("sleep", 32'(sleeping), 32'h1);
		rdchk("ctl kept", `OFS_CONTROL, 32'hFFFFFFFF, 32'h0FE);
		e0_v <= 1'h1;
		repeat (SETTLE) @(posedge hclk);
		chk("slow rise asleep", 32'(sleeping), 32'h1);
		e0_v <= 1'h0;
		apply(32'h0F4, `CMD_KEEP);
		chk("wake", 32'(sleeping), 32'h0);
	endtask
	task t_modes;
		logic [3:0] m [4];
		logic [2:0] e [4];
		m = '{`MODE_BUS_VOLTAGE_RESULT_ONLY, `MODE_SHUNT_ONLY, `MODE_8SPS, `MODE_1024};
		e = '{3'h4, 3'h2, 3'h7, 3'h6};
		for (int i = 0; i < 4; i++) begin
			apply({28'h0, m[i]}, `CMD_KEEP);
			chk("mode", 32'({sample_bus, sample_shunt, slow_active}), 32'(e[i]));
		end
	endtask
	task t_slow;
		apply(32'h0F4, `CMD_KEEP);
		xfer(1'h1, `OFS_SLOW_CFG, 32'h36);
		e0_v <= 1'h1;
		repeat (SETTLE) @(posedge hclk);
		chk("slow pin0", 32'(slow_active), 32'h1);
		rdchk("slow status", `OFS_SLOW_CFG, 32'h3F, 32'h1E);
		e0_v <= 1'h0;
		e1_v <= 1'h1;
		repeat (SETTLE) @(posedge hclk);
		chk("pin0 precedes", 32'(slow_active), 32'h0);
		apply(32'h0D4, `CMD_KEEP);
		chk("slow pin1", 32'(slow_active), 32'h1);
		e1_v <= 1'h0;
		e0_en <= 1'h0;
		apply(32'h0C4, `CMD_KEEP);
		chk("alert pin high", 32'(slow_active), 32'h0);
		alert_zero_req <= 1'h1;
		repeat (4) @(posedge hclk);
		chk("alert drive", 32'({oe0, out0, oe1}), 32'h4);
		alert_zero_req <= 1'h0;
	endtask
	task t_gpio;
		e0_en <= 1'h1;
		e0_v <= 1'h0;
		apply(32'h094, `CMD_KEEP);
		rdchk("gpi low", `OFS_BUS_SETTINGS, 32'h1, 32'h0);
		e0_v <= 1'h1;
		repeat (4) @(posedge hclk);
		rdchk("gpi high", `OFS_BUS_SETTINGS, 32'h1, 32'h1);
		for (int i = 1; i >= 0; i--) begin
			xfer(1'h1, `OFS_BUS_SETTINGS, 32'(i * 2));
			repeat (2) @(posedge hclk);
			chk("gpo", 32'({oe1, out1}), 32'(2 + i));
		end
	endtask
	task t_snap;
		int n0;
		for (int c = 1; c <= 2; c++) begin
			n0 = snap_n;
			xfer(1'h1, `OFS_COMMAND, 32'(c));
			repeat (SETTLE) @(posedge hclk);
			chk("snap", 32'({snap_n != n0, last_clr}), (2'(c) == `CMD_FULL) ? 32'h3 : 32'h2);
		end
	endtask
	task t_power_down_pin;
		apply(32'h1F4, `CMD_KEEP);
		rdchk("adaptive", `OFS_SLOW_CFG, 32'h6, 32'h0);
		xfer(1'h1, `OFS_CONTROL, 32'h0FE);
		power_down_pin <= 1'h0;
		repeat (6) @(posedge hclk);
		power_down_pin <= 1'h1;
		repeat (6) @(posedge hclk);
		rdchk("ctl default", `OFS_CONTROL, 32'hFFFFFFFF, 32'h0F4);
		rdchk("por again", `OFS_BUS_SETTINGS, 32'h80, 32'h80);
	endtask
	// single-shot idle, band-gap wait on a slow rise, then back to idle
	task t_shot;
		e0_v <= 1'h0;
		apply(32'h0FC, `CMD_KEEP);
		rdchk("shot idle", `OFS_STATUS, 32'hF, 32'h8);
		e0_v <= 1'h1;
		repeat (4) @(posedge hclk);
		rdchk("band-gap wait", `OFS_STATUS, 32'hF, 32'h4);
		repeat (SETTLE) @(posedge hclk);
		rdchk("shot done", `OFS_STATUS, 32'hF, 32'h8);
		e0_v <= 1'h0;
	endtask
	task final_report;
		if (fail_count == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// ----------
	// run
	// ----------
	initial begin
		hclk = 1'h0;
		forever #5 hclk = ~hclk;
	end
	// watchdog against a hang
	initial begin
		#300000;
		fail_count++;
		final_report;
	end
	initial begin
		{hsel, hwrite, alert_zero_req, e0_v, e1_v, hresetn} = 6'h0;
		{power_down_pin, e0_en, e1_en} = 3'h7;
		haddr = 12'h0;
		htrans = 2'h0;
		hwdata = 32'h0;
		repeat (5) @(posedge hclk);
		hresetn <= 1'h1;
		// power-down synchroniser keeps the core in reset two more edges
		repeat (2) @(posedge hclk);
		t_reset;
		repeat (POR_WAIT) @(posedge hclk);
		t_sleep;
		t_modes;
		t_slow;
		t_gpio;
		t_snap;
		t_shot;
		t_power_down_pin;
		final_report;
	end
endmodule
`default_nettype wire
